// file: logic/cir_pkg.sv
package cir_pkg;

	localparam int unsigned CIR_NCTR   = 6;
	localparam int unsigned CIR_NCH    = 16;
	localparam int unsigned CIR_AW     = 12;
	localparam int unsigned CIR_CTRL_W = 15;

	// Register byte offsets; counter k control word sits at CTRL0 + 4*(k-1)
	localparam logic [11:0] CIR_OFF_CTRL0 = 12'h000;
	localparam logic [11:0] CIR_OFF_DOUT  = 12'h018;
	localparam logic [11:0] CIR_OFF_DIN   = 12'h01C;
	localparam logic [11:0] CIR_OFF_ERR   = 12'h020;
	localparam logic [11:0] CIR_OFF_LOGIC = 12'h024;
	localparam logic [11:0] CIR_OFF_ROUTE = 12'h028;

	// Control word fields
	localparam int unsigned CIR_F_EN      = 0;
	localparam int unsigned CIR_F_TYPE    = 1;
	localparam int unsigned CIR_F_AUX0_EN = 3;
	localparam int unsigned CIR_F_AUX0    = 4;
	localparam int unsigned CIR_F_AUX1_EN = 8;
	localparam int unsigned CIR_F_AUX1    = 9;
	localparam int unsigned CIR_F_PIN_EN  = 13;
	localparam int unsigned CIR_F_PIN_HI  = 14;

	localparam logic [CIR_CTRL_W-1:0] CIR_CTRL_RST = 15'h0000;
	localparam logic [15:0]           CIR_DOUT_RST = 16'h0000;

	// Signal types: A only, A+B, A+B+N
	localparam logic [1:0] CIR_SIG_A   = 2'h0;
	localparam logic [1:0] CIR_SIG_AB  = 2'h1;
	localparam logic [1:0] CIR_SIG_ABN = 2'h2;
	localparam logic [1:0] CIR_SIG_RSV = 2'h3;

	// Per-counter tables, element k belongs to counter k+1
	localparam logic [5:0][3:0]  CIR_A_CH   = {4'hE, 4'hB, 4'h8, 4'h6, 4'h3, 4'h0};
	localparam logic [5:0]       CIR_HAS_N  = 6'h1B;
	localparam logic [5:0][15:0] CIR_AUX_OK = {16'hBF00, 16'hF700, 16'hFE00,
	                                           16'h00BF, 16'h00F7, 16'h00FE};
	localparam logic [5:0][3:0]  CIR_PIN_LO = {4'h6, 4'h7, 4'h5, 4'h4, 4'h3, 4'h1};
	localparam logic [5:0][3:0]  CIR_PIN_HI = {4'hE, 4'hF, 4'hD, 4'hC, 4'hB, 4'h9};

	// Standard output delay bound
	localparam int unsigned CIR_CLK_NS      = 25;
	localparam int unsigned CIR_STD_DLY_NS  = 500000;
	localparam int unsigned CIR_STD_DLY_CYC = CIR_STD_DLY_NS / CIR_CLK_NS;

endpackage

// file: logic/cir_sync_if.sv
`timescale 1ns/1ps
interface cir_sync_if;
	logic [cir_pkg::CIR_NCH-1:0] lvl;
	modport src (output lvl);
	modport dst (input lvl);
endinterface

// file: logic/cir_sync.sv
`timescale 1ns/1ps
module cir_sync (
	input  wire logic                        clk,
	input  wire logic                        arst_n,
	input  wire logic [cir_pkg::CIR_NCH-1:0] din_raw,
	cir_sync_if.src                          sif
);
	import cir_pkg::*;

	logic [CIR_NCH-1:0] meta_q;
	logic [CIR_NCH-1:0] sync_q;

	for (genvar b = 0; b < CIR_NCH; b++) begin : g_bit
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				meta_q[b] <= 1'b0;
				sync_q[b] <= 1'b0;
			end else begin
				meta_q[b] <= din_raw[b];
				sync_q[b] <= meta_q[b];
			end
		end
	end

	assign sif.lvl = sync_q;
endmodule

// file: logic/cir_route.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Any of six counters takes inputs 0..15 within the allowed combinations.
// - Track A fixed per counter; B and N on next inputs when type needs.
// - Inputs claimed as B or N cannot serve as auxiliary inputs.
// - Optional inputs feed the counter or stay plain readable inputs.
// - Counter logic output is register-readable only, never on a pin.
// - Counter pin output routes to one of its two fixed output channels.
// - Outputs without a counter stay program-driven standard outputs.
// - Standard outputs follow a written value within 500 microseconds.
module cir_route #(
	parameter int unsigned STD_DLY_CYC = cir_pkg::CIR_STD_DLY_CYC
) (
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [cir_pkg::CIR_AW-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic [cir_pkg::CIR_NCH-1:0]  di_pin,
	output logic      [cir_pkg::CIR_NCH-1:0]  dq_pin,
	input  wire logic [cir_pkg::CIR_NCTR-1:0] counter_logic_output,
	input  wire logic [cir_pkg::CIR_NCTR-1:0] counter_pin_output,
	output logic      [cir_pkg::CIR_NCTR-1:0] track_a,
	output logic      [cir_pkg::CIR_NCTR-1:0] track_b,
	output logic      [cir_pkg::CIR_NCTR-1:0] track_n,
	output logic      [cir_pkg::CIR_NCTR-1:0] counter_aux_input_0,
	output logic      [cir_pkg::CIR_NCTR-1:0] counter_aux_input_1,
	output logic      [cir_pkg::CIR_NCTR-1:0] cfg_err
);
	import cir_pkg::*;

	if (STD_DLY_CYC < 2) begin : g_chk
		$error("STD_DLY_CYC below the two-cycle output path");
	end

	function automatic logic [CIR_NCH-1:0] onehot(input logic [3:0] ch);
		onehot = 16'h0001 << ch;
	endfunction

	cir_sync_if u_sif ();
	cir_sync u_sync (
		.clk     (clk),
		.arst_n  (arst_n),
		.din_raw (di_pin),
		.sif     (u_sif.src)
	);
	logic [CIR_NCH-1:0] di_s;
	assign di_s = u_sif.lvl;

	logic [CIR_CTRL_W-1:0] ctrl_q [CIR_NCTR];
	logic [15:0]           dout_q;
	logic [31:0]           prdata_q;
	logic                  pslverr_q;
	logic [CIR_NCTR-1:0]   err_d;
	logic [CIR_NCTR-1:0]   err_q;
	logic [CIR_NCTR-1:0]   ok;
	logic [CIR_NCTR-1:0]   en;
	logic [CIR_NCTR-1:0]   pin_ok;
	logic [1:0]            typ   [CIR_NCTR];
	logic [3:0]            aux0  [CIR_NCTR];
	logic [3:0]            aux1  [CIR_NCTR];
	logic [CIR_NCTR-1:0]   aux0_en;
	logic [CIR_NCTR-1:0]   aux1_en;
	logic [CIR_NCH-1:0]    own   [CIR_NCTR];
	logic [CIR_NCH-1:0]    bn    [CIR_NCTR];
	logic [CIR_NCH-1:0]    dq_d;
	logic [CIR_NCH-1:0]    routed_d;
	logic [CIR_NCH-1:0]    routed_q;
	logic [CIR_NCH-1:0]    dq_q;
	logic                  wr_acc;
	logic                  rd_hit;
	logic [31:0]           rd_d;

	// Zero wait states; read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;
	assign wr_acc  = psel && penable && pwrite;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < CIR_NCTR; i++) begin
				ctrl_q[i] <= CIR_CTRL_RST;
			end
		end else if (wr_acc) begin
			for (int i = 0; i < CIR_NCTR; i++) begin
				if (paddr == CIR_OFF_CTRL0 + 12'(4 * i)) begin
					ctrl_q[i] <= pwdata[CIR_CTRL_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dout_q <= CIR_DOUT_RST;
		end else if (wr_acc && paddr == CIR_OFF_DOUT) begin
			dout_q <= pwdata[15:0];
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_d   = 32'h0000_0000;
		if (paddr == CIR_OFF_DOUT) begin
			rd_d[15:0] = dout_q;
		end else if (paddr == CIR_OFF_DIN) begin
			rd_d[15:0] = di_s;
		end else if (paddr == CIR_OFF_ERR) begin
			rd_d[CIR_NCTR-1:0] = err_q;
		end else if (paddr == CIR_OFF_LOGIC) begin
			rd_d[CIR_NCTR-1:0] = counter_logic_output;
		end else if (paddr == CIR_OFF_ROUTE) begin
			rd_d[15:0] = routed_q;
		end else begin
			rd_hit = 1'b0;
			for (int i = 0; i < CIR_NCTR; i++) begin
				if (paddr == CIR_OFF_CTRL0 + 12'(4 * i)) begin
					rd_hit                = 1'b1;
					rd_d[CIR_CTRL_W-1:0] = ctrl_q[i];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
			pslverr_q <= !rd_hit;
		end
	end

	// Claims per counter; a channel may hold only one role device-wide
	always_comb begin
		for (int i = 0; i < CIR_NCTR; i++) begin
			en[i]      = ctrl_q[i][CIR_F_EN];
			typ[i]     = ctrl_q[i][CIR_F_TYPE +: 2];
			aux0_en[i] = ctrl_q[i][CIR_F_AUX0_EN];
			aux1_en[i] = ctrl_q[i][CIR_F_AUX1_EN];
			aux0[i]    = ctrl_q[i][CIR_F_AUX0 +: 4];
			aux1[i]    = ctrl_q[i][CIR_F_AUX1 +: 4];
			bn[i]      = '0;
			if (typ[i] != CIR_SIG_A) begin
				bn[i] = bn[i] | onehot(4'(CIR_A_CH[i] + 4'h1));
			end
			if (typ[i] == CIR_SIG_ABN) begin
				bn[i] = bn[i] | onehot(4'(CIR_A_CH[i] + 4'h2));
			end
			own[i] = onehot(CIR_A_CH[i]) | bn[i];
			if (aux0_en[i]) begin
				own[i] = own[i] | onehot(aux0[i]);
			end
			if (aux1_en[i]) begin
				own[i] = own[i] | onehot(aux1[i]);
			end
			if (!en[i]) begin
				own[i] = '0;
			end
			err_d[i] = (typ[i] == CIR_SIG_RSV) || (typ[i] == CIR_SIG_ABN && !CIR_HAS_N[i])
				|| (aux0_en[i] && (!CIR_AUX_OK[i][aux0[i]] || bn[i][aux0[i]]))
				|| (aux1_en[i] && (!CIR_AUX_OK[i][aux1[i]] || bn[i][aux1[i]]))
				|| (aux0_en[i] && aux1_en[i] && aux0[i] == aux1[i]);
		end
		for (int i = 0; i < CIR_NCTR; i++) begin
			for (int j = 0; j < CIR_NCTR; j++) begin
				if (j != i && |(own[i] & own[j])) begin
					err_d[i] = 1'b1;
				end
			end
			err_d[i] = err_d[i] && en[i];
			ok[i]    = en[i] && !err_d[i];
			pin_ok[i] = ok[i] && ctrl_q[i][CIR_F_PIN_EN];
		end
	end

	// A faulty counter gets no inputs at all rather than a partial set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			track_a             <= '0;
			track_b             <= '0;
			track_n             <= '0;
			counter_aux_input_0 <= '0;
			counter_aux_input_1 <= '0;
			err_q               <= '0;
		end else begin
			err_q <= err_d;
			for (int i = 0; i < CIR_NCTR; i++) begin
				track_a[i]             <= ok[i] && di_s[CIR_A_CH[i]];
				track_b[i]             <= ok[i] && |(bn[i] & di_s & onehot(4'(CIR_A_CH[i] + 4'h1)));
				track_n[i]             <= ok[i] && |(bn[i] & di_s & onehot(4'(CIR_A_CH[i] + 4'h2)));
				counter_aux_input_0[i] <= ok[i] && aux0_en[i] && di_s[aux0[i]];
				counter_aux_input_1[i] <= ok[i] && aux1_en[i] && di_s[aux1[i]];
			end
		end
	end
	assign cfg_err = err_q;

	// Pin outputs: counter route where enabled, standard value everywhere else
	always_comb begin
		dq_d     = dout_q;
		routed_d = '0;
		for (int i = 0; i < CIR_NCTR; i++) begin
			if (pin_ok[i]) begin
				if (ctrl_q[i][CIR_F_PIN_HI]) begin
					dq_d[CIR_PIN_HI[i]]     = counter_pin_output[i];
					routed_d[CIR_PIN_HI[i]] = 1'b1;
				end else begin
					dq_d[CIR_PIN_LO[i]]     = counter_pin_output[i];
					routed_d[CIR_PIN_LO[i]] = 1'b1;
				end
			end
		end
	end

	// Two cycles from write to pin, far inside the allowed delay
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dq_q     <= '0;
			routed_q <= '0;
		end else begin
			dq_q     <= dq_d;
			routed_q <= routed_d;
		end
	end
	assign dq_pin = dq_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_setup_rd(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	sequence s_dout_wr;
		psel && !penable && pwrite && paddr == CIR_OFF_DOUT ##1 psel && penable;
	endsequence

	chk_fixed_track_a: assert property (ok[1] |=> track_a[1] == $past(di_s[3]))
		else $error("track A of counter 2 not fed from input 3");
	chk_b_only_typed: assert property (!(ok[0] && typ[0] != CIR_SIG_A) |=> !track_b[0])
		else $error("track B driven without a B signal type");
	chk_bn_over_aux: assert property (
		(en[0] && typ[0] != CIR_SIG_A && aux0_en[0] && aux0[0] == 4'h1) |=> cfg_err[0])
		else $error("aux input on a B channel not refused");
	chk_aux_routing: assert property (
		(ok[3] && aux0_en[3]) |=> counter_aux_input_0[3] == $past(di_s[aux0[3]]))
		else $error("aux input 0 of counter 4 misrouted");
	chk_din_readback: assert property (s_setup_rd(CIR_OFF_DIN) |=> prdata[15:0] == $past(di_s))
		else $error("plain input readback wrong");
	chk_logic_out_rd: assert property (
		s_setup_rd(CIR_OFF_LOGIC) |=> prdata[CIR_NCTR-1:0] == $past(counter_logic_output))
		else $error("counter logic output readback wrong");
	chk_pin_routing: assert property (
		(pin_ok[1] && !ctrl_q[1][CIR_F_PIN_HI]) |=> dq_pin[3] == $past(counter_pin_output[1]))
		else $error("counter 2 pin output not on channel 3");
	chk_free_channels: assert property (
		1'b1 |=> {dq_pin[10], dq_pin[8], dq_pin[2], dq_pin[0]}
			== $past({dout_q[10], dout_q[8], dout_q[2], dout_q[0]}))
		else $error("channel without counter not standard");
	chk_std_out_delay: assert property (
		s_dout_wr |=> ##1 ((dq_pin ^ $past(pwdata[15:0], 2)) & ~routed_q) == 16'h0000)
		else $error("standard output late");
	chk_dual_claim: assert property (
		(en[0] && en[1] && aux0_en[1] && aux0[1] == 4'h0) |=> (cfg_err[1] && !track_a[1]))
		else $error("double claim of input 0 not flagged");

endmodule

// file: bench/cir_partner.sv
`timescale 1ns/1ps
module cir_partner (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        step,
	input  wire logic [15:0] other,
	input  wire logic [15:0] dq_pin,
	output logic      [15:0] di_pin
);
	logic [1:0] phase_q;
	logic [7:0] pos_q;
	// Encoder moves one quarter step per enabled edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= 2'h0;
			pos_q   <= 8'h00;
		end else if (step) begin
			phase_q <= phase_q + 2'h1;
			pos_q   <= pos_q + 8'h01;
		end
	end
	// Gray order keeps A and B a quarter apart; loads on dq_pin draw no signal back
	always_comb begin
		di_pin    = other;
		di_pin[0] = phase_q[1];
		di_pin[1] = phase_q[1] ^ phase_q[0];
		di_pin[2] = (pos_q == 8'h00);
	end
endmodule

// file: bench/test_counter_io_routing.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %0t got %0h exp %0h", $time, (g), (e)); end end
module test_counter_io_routing;
	import cir_pkg::*;
	logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, step = 0, pready, perr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] di_pin, dq_pin, dv, ex, other = 16'h0000;
	logic [5:0]  lo_out = 6'h00, pin_out = 6'h00, ta, tb, tn, ax0, ax1, cfg_err;
	int          num_errors = 0, comparisons = 0, seed = 32'hef70c531, a0, a1, ch;
	int          lo_ch[6] = '{1, 3, 4, 5, 7, 6};
	int          a_ch[6] = '{0, 3, 6, 8, 11, 14};

	always #12.5 clk = ~clk;

	cir_route #(.STD_DLY_CYC(4)) cir_route_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(perr), .di_pin(di_pin), .dq_pin(dq_pin),
		.counter_logic_output(lo_out), .counter_pin_output(pin_out), .track_a(ta),
		.track_b(tb), .track_n(tn), .counter_aux_input_0(ax0), .counter_aux_input_1(ax1),
		.cfg_err(cfg_err));
	cir_partner cir_partner_inst (.clk(clk), .arst_n(arst_n), .step(step), .other(other),
		.dq_pin(dq_pin), .di_pin(di_pin));

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [31:0] ctrl(input int t, x0, x1, pin);
		int v;
		v = 1 | (t << 1);
		if (x0 >= 0) v = v | 8 | (x0 << 4);
		if (x1 >= 0) v = v | 256 | (x1 << 9);
		if (pin >= 0) v = v | 8192 | (pin << 14);
		return 32'(v);
	endfunction

	task test_done;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#500000;
		num_errors++;
		test_done;
	end

	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		apb(0, CIR_OFF_DOUT, 0);
		`CHK(rd, 32'h0)
		apb(0, 12'h0FC, 0);
		`CHK(perr, 1'b1)
		`CHK(pready, 1'b1)
		dv = 16'($random(seed));
		apb(1, CIR_OFF_DOUT, {16'h0000, dv});
		#1 `CHK(dq_pin, dv)
		// Track routing with a moving encoder, aux picks avoid B and N
		for (int i = 0; i < 8; i++) begin
			a0 = 3 + ((32'($random(seed)) & 32'h7FFF) % 5);
			a1 = (a0 == 7) ? 3 : a0 + 1;
			apb(1, CIR_OFF_CTRL0, ctrl(2, a0, a1, -1));
			step  <= 1'b1;
			other <= 16'($random(seed));
			repeat (6) @(posedge clk);
			step <= 1'b0;
			repeat (4) @(posedge clk);
			#1 `CHK(ta[0], di_pin[0])
			`CHK(tb[0], di_pin[1])
			`CHK(tn[0], di_pin[2])
			`CHK(ax0[0], di_pin[a0])
			`CHK(ax1[0], di_pin[a1])
			`CHK(cfg_err, 6'h00)
			apb(0, CIR_OFF_DIN, 0);
			`CHK(rd[15:0], di_pin)
		end
		// Aux on a channel already claimed as track B
		apb(1, CIR_OFF_CTRL0, ctrl(1, 1, 3, -1));
		repeat (2) @(posedge clk);
		#1 `CHK(cfg_err[0], 1'b1)
		`CHK(ta[0], 1'b0)
		// Counter 2 takes counter 1's track A as aux: both flagged
		apb(1, CIR_OFF_CTRL0, ctrl(0, 3, -1, -1));
		apb(1, CIR_OFF_CTRL0 + 12'h004, ctrl(0, 0, -1, -1));
		apb(0, CIR_OFF_ERR, 0);
		`CHK(rd[5:0], 6'h03)
		apb(1, CIR_OFF_CTRL0 + 12'h004, 0);
		apb(1, CIR_OFF_CTRL0, 0);
		// Pin routes, both channel choices of every counter
		dv = 16'($random(seed));
		apb(1, CIR_OFF_DOUT, {16'h0000, dv});
		for (int k = 0; k < 6; k++) begin
			for (int h = 0; h < 2; h++) begin
				apb(1, CIR_OFF_CTRL0 + 12'(4 * k), ctrl(0, -1, -1, h));
				pin_out <= 6'($random(seed));
				lo_out  <= 6'($random(seed));
				repeat (2) @(posedge clk);
				#1 ch = lo_ch[k] + 8 * h;
				ex = dv;
				ex[ch] = pin_out[k];
				`CHK(dq_pin, ex)
				`CHK(ta[k], di_pin[a_ch[k]])
				apb(0, CIR_OFF_ROUTE, 0);
				`CHK(rd[15:0], 16'(1 << ch))
				apb(0, CIR_OFF_LOGIC, 0);
				`CHK(rd[5:0], lo_out)
				apb(1, CIR_OFF_CTRL0 + 12'(4 * k), 0);
			end
		end
		test_done;
	end
endmodule
